// >>> design/tick_pkg.sv
/*
 * package for the system tick down counter: register offsets, field
 * positions, reset values and widths.
 * assumes a 32-bit classic wishbone register bus on mclk.
 */
package tick_pkg;
    localparam int CNT_W = 24;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] PERIOD_OFS = 4'h4;
    localparam logic [3:0] CURRENT_OFS = 4'h8;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_IE_BIT = 1;
    localparam int CTRL_ROLL_BIT = 16;
    localparam logic [24:0] PERIOD_RST = 25'h1000000;
    localparam logic [24:0] PERIOD_MAX = 25'h1000000;
    localparam logic [24:0] PERIOD_MIN = 25'h0000001;
endpackage

// >>> design/tick_core.sv
/*
 * 24-bit down counter with reload and rollover pulse.
 * assumes reload value is period minus one, held by the parent.
 */
`timescale 1ns/100ps
`default_nettype none
module tick_core #(
    parameter int W = 24
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic clear,
    input wire logic [W-1:0] reload,
    // state
    output logic [W-1:0] count,
    output logic roll
);
    typedef struct packed {
        logic [W-1:0] count;
        logic roll;
    } core_t;
    core_t st_r;
    core_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.roll = 1'b0;
        if (clear) begin
            st_nxt.count = '0;
        end else if (run) begin
            if (st_r.count == '0) begin
                st_nxt.count = reload;
                st_nxt.roll = 1'b1;
            end else begin
                st_nxt.count = st_r.count - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count = st_r.count;
    assign roll = st_r.roll;

    hold_still_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !run && !clear |=> $stable(st_r.count) && !st_r.roll) else $error("counter moved while stopped");

    if (W < 1) begin : g_bad_width
        $error("tick_core width must be at least one");
    end
endmodule
`default_nettype wire

// >>> design/system_tick_timer.sv
/*
 * system tick timer: periodic down counter with a wishbone register
 * slave and one interrupt request line.
 * assumes classic wishbone on mclk, synchronous active-low reset, and an
 * interrupt controller that pulses int_taken when the handler is entered.
 */
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module system_tick_timer (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // processor interrupt
    input wire logic int_taken,
    output logic tick_irq
);
    localparam int W = tick_pkg::CNT_W;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic en;
        logic ie;
        logic [24:0] period;
        logic roll_seen;
        logic pend;
        logic ack;
        logic err;
        logic [31:0] dat;
    } tick_state_t;
    tick_state_t st_r;
    tick_state_t st_nxt;

    logic [W-1:0] count;
    logic roll;
    logic clear;
    logic [W-1:0] reload;
    logic req;
    logic wr;

    assign req = wb_cyc_i && wb_stb_i && !st_r.ack && !st_r.err;
    assign wr = req && wb_we_i && (wb_sel_i != 4'h0);
    assign clear = wr && (wb_adr_i == tick_pkg::CURRENT_OFS);
    assign reload = W'(st_r.period - 25'h0000001);

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    tick_core #(.W(W)) u_core (
        .mclk(mclk),
        .rst_n(rst_n),
        .run(st_r.en),
        .clear(clear),
        .reload(reload),
        .count(count),
        .roll(roll)
    );

    // ------------------------------------------------------------
    // registers and interrupt
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.err = 1'b0;
        st_nxt.dat = 32'h00000000;
        if (roll) begin
            st_nxt.roll_seen = 1'b1;
        end
        if (int_taken) begin
            st_nxt.pend = 1'b0;
        end
        if (roll && st_r.ie) begin
            st_nxt.pend = 1'b1;
        end
        if (req) begin
            case (wb_adr_i)
                tick_pkg::CTRL_OFS: begin
                    st_nxt.ack = 1'b1;
                    st_nxt.dat[tick_pkg::CTRL_EN_BIT] = st_r.en;
                    st_nxt.dat[tick_pkg::CTRL_IE_BIT] = st_r.ie;
                    st_nxt.dat[tick_pkg::CTRL_ROLL_BIT] = st_r.roll_seen;
                    if (wb_we_i && wb_sel_i[0]) begin
                        st_nxt.en = wb_dat_i[tick_pkg::CTRL_EN_BIT];
                        st_nxt.ie = wb_dat_i[tick_pkg::CTRL_IE_BIT];
                    end
                    if (!wb_we_i && !roll) begin
                        st_nxt.roll_seen = 1'b0;
                    end
                end
                tick_pkg::PERIOD_OFS: begin
                    st_nxt.ack = 1'b1;
                    st_nxt.dat = {7'h00, st_r.period};
                    if (wb_we_i && wb_sel_i == 4'hF) begin
                        if (wb_dat_i[24:0] >= tick_pkg::PERIOD_MIN && wb_dat_i[31:25] == 7'h00
                            && wb_dat_i[24:0] <= tick_pkg::PERIOD_MAX) begin
                            st_nxt.period = wb_dat_i[24:0];
                        end
                    end
                end
                tick_pkg::CURRENT_OFS: begin
                    st_nxt.ack = 1'b1;
                    st_nxt.dat = {8'h00, count};
                end
                default: begin
                    st_nxt.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '{en: 1'b0, ie: 1'b0, period: tick_pkg::PERIOD_RST, roll_seen: 1'b0,
                      pend: 1'b0, ack: 1'b0, err: 1'b0, dat: 32'h00000000};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o = st_r.dat;
    assign wb_ack_o = st_r.ack;
    assign wb_err_o = st_r.err;
    assign tick_irq = st_r.pend;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [24:0] gap_r;
    logic seen_r;
    logic [24:0] lim_r;
    always_ff @(posedge mclk) begin
        if (!rst_n || !st_r.en || clear || $changed(st_r.period)) begin
            gap_r <= 25'h0000000;
            seen_r <= 1'b0;
        end else if (roll) begin
            gap_r <= 25'h0000001;
            seen_r <= 1'b1;
        end else begin
            gap_r <= gap_r + 25'h0000001;
        end
    end

    // largest count allowed since the last reload
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lim_r <= 25'h0000000;
        end else if (st_r.en && count == '0 && !clear) begin
            lim_r <= st_r.period - 25'h0000001;
        end
    end

    count_range_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(roll) |-> {1'b0, count} <= st_r.period - 25'h0000001) else $error("count above period");
    count_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
        {1'b0, count} <= lim_r) else $error("count above reload value");
    roll_gap_a: assert property (@(posedge mclk) disable iff (!rst_n)
        roll && seen_r && st_r.en && !$past(clear) |-> gap_r == $past(st_r.period)) else $error("bad rollover gap");
    enable_resume_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(st_r.en) && count != '0 && !clear |=> count == $past(count) - 1'b1) else $error("reload on enable");
    clear_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clear |=> count == '0) else $error("clear missed");
    clear_reload_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clear && st_r.en |=> ##1 (count == $past(reload) && roll)) else $error("no reload after clear");
    period_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        req && wb_we_i && wb_adr_i == tick_pkg::PERIOD_OFS && st_r.en && count != '0
        |=> count == $past(count) - 1'b1) else $error("period write disturbed count");
    irq_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        roll && !st_r.ie && !st_r.pend |=> !tick_irq) else $error("masked rollover raised irq");
    irq_only_roll_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(tick_irq) |-> $past(roll) && $past(st_r.ie)) else $error("irq without enabled rollover");
    irq_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        roll && st_r.ie |=> tick_irq) else $error("rollover irq lost");
    irq_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        int_taken && !(roll && st_r.ie) |=> !tick_irq) else $error("irq not cleared");
    irq_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        tick_irq && !int_taken |=> tick_irq) else $error("irq dropped before taken");
    period_range_a: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.period >= tick_pkg::PERIOD_MIN && st_r.period <= tick_pkg::PERIOD_MAX)
        else $error("period out of range");
    period_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        req && !wb_we_i && wb_adr_i == tick_pkg::PERIOD_OFS |=> wb_dat_o == {7'h00, $past(st_r.period)})
        else $error("period readback wrong");
    ack_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o) else $error("ack held");
    err_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_err_o |=> !wb_err_o) else $error("err held");
    dat_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !wb_ack_o |-> wb_dat_o == 32'h00000000) else $error("read data without ack");

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    cover_roll_c: cover property (@(posedge mclk) disable iff (!rst_n) roll && st_r.ie);
    cover_clear_c: cover property (@(posedge mclk) disable iff (!rst_n) clear && st_r.en);
    cover_taken_c: cover property (@(posedge mclk) disable iff (!rst_n) tick_irq ##1 int_taken);
    cover_resume_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(st_r.en) && count != '0);
    cover_err_c: cover property (@(posedge mclk) disable iff (!rst_n) wb_err_o);
endmodule
`default_nettype wire

// >>> dv/testbench.sv
/*
 * self-checking bench for the system tick timer: wishbone tasks, read queue, irq spacing.
 * assumes design/tick_pkg.sv and design/system_tick_timer.sv are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, int_taken = 0, irq_q = 0, e;
    logic [3:0] adr = 4'h0, sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, exp_p = 0, cyc_n = 0, last = 0, irq_n = 0, n0, r = 32'he74c1e55;
    logic ack, err, tick_irq;
    logic [31:0] q[$];
    int mismatches = 0, checks = 0;
    system_tick_timer u_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .int_taken(int_taken), .tick_irq(tick_irq));
    always #4 mclk = ~mclk;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want) begin
            mismatches++;
            $display("[FAIL] %0t value mismatch got %h exp %h", $time, got, want);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic er);
        @(posedge mclk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do @(posedge mclk); while (!(ack | err));
        er = err;
        cyc <= 0; stb <= 0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1, a, d, e);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] x);
        q.push_back(x);
        bus(0, a, 32'h0, e);
    endtask
    // ----------------------------------------
    // monitors
    // ----------------------------------------
    always @(posedge mclk) begin
        if (ack && cyc && !we && q.size() > 0) chk(rdat, q.pop_front());
    end
    always @(posedge mclk) begin
        int_taken <= tick_irq && !int_taken;
        cyc_n <= cyc_n + 1;
        irq_q <= tick_irq;
        if (tick_irq && !irq_q) begin
            irq_n <= irq_n + 1;
            if (last != 0 && exp_p != 0) chk(cyc_n - last, exp_p);
            last <= cyc_n;
        end
    end
    initial begin
        repeat (30000) @(posedge mclk);
        mismatches++;
        finish_test;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1;
        rd(tick_pkg::CTRL_OFS, 32'h0);
        rd(tick_pkg::PERIOD_OFS, 32'h01000000);
        rd(tick_pkg::CURRENT_OFS, 32'h0);
        bus(0, 4'hC, 32'h0, e);
        chk(e, 1);
        bus(1, 4'h2, 32'h0, e);
        chk(e, 1);
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            wr(tick_pkg::PERIOD_OFS, (r % 32'h01000000) + 1);
            rd(tick_pkg::PERIOD_OFS, (r % 32'h01000000) + 1);
        end
        wr(tick_pkg::PERIOD_OFS, 32'h01000000);
        wr(tick_pkg::PERIOD_OFS, 32'h0);
        wr(tick_pkg::PERIOD_OFS, 32'h01000001);
        rd(tick_pkg::PERIOD_OFS, 32'h01000000);
        sel <= 4'h0;
        wr(tick_pkg::PERIOD_OFS, 32'h7);
        sel <= 4'hF;
        wr(tick_pkg::PERIOD_OFS, 32'h5);
        rd(tick_pkg::PERIOD_OFS, 32'h5);
        wr(tick_pkg::CURRENT_OFS, r);
        rd(tick_pkg::CURRENT_OFS, 32'h0);
        exp_p = 5;
        wr(tick_pkg::CTRL_OFS, 32'h3);
        repeat (40) @(posedge mclk);
        chk(irq_n > 5, 1);
        exp_p = 0;
        wr(tick_pkg::PERIOD_OFS, 32'h9);
        repeat (25) @(posedge mclk);
        exp_p = 9;
        repeat (40) @(posedge mclk);
        chk(irq_n > 9, 1);
        wr(tick_pkg::CTRL_OFS, 32'h1);
        repeat (5) @(posedge mclk);
        n0 = irq_n;
        repeat (40) @(posedge mclk);
        chk(irq_n, n0);
        rd(tick_pkg::CTRL_OFS, 32'h00010001);
        wr(tick_pkg::CURRENT_OFS, r);
        wr(tick_pkg::CTRL_OFS, 32'h0);
        n0 = irq_n;
        rd(tick_pkg::CURRENT_OFS, 32'h6);
        bus(0, tick_pkg::CTRL_OFS, 32'h0, e);
        repeat (30) @(posedge mclk);
        rd(tick_pkg::CURRENT_OFS, 32'h6);
        rd(tick_pkg::CTRL_OFS, 32'h0);
        wr(tick_pkg::CTRL_OFS, 32'h2);
        repeat (30) @(posedge mclk);
        chk(irq_n, n0);
        chk(tick_irq, 0);
        exp_p = 0;
        wr(tick_pkg::CTRL_OFS, 32'h3);
        rd(tick_pkg::CURRENT_OFS, 32'h4);
        repeat (40) @(posedge mclk);
        chk(irq_n > n0 + 2, 1);
        finish_test;
    end
endmodule
`default_nettype wire
